// file: src/ext_mem_if_pkg.sv
package ext_mem_if_pkg;
    // control register field positions
    localparam int ENABLE_BIT       = 7;
    localparam int UPPER_W0_BIT     = 6;
    localparam int EXT_UPPER_W1_BIT = 1;
    localparam int EXT_LOWER_W0_BIT = 2;
    localparam int EXT_LOWER_W1_BIT = 3;
    localparam int EXT_LIMIT_LSB    = 4;
    localparam int SF_MASK_LSB      = 3;
    localparam int SF_KEEPER_BIT    = 6;
    localparam int LIMIT_W          = 3;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // address map
    localparam logic [15:0] EXT_BASE    = 16'h0260;
    localparam logic [15:0] SECTOR_STEP = 16'h2000;
    // wait codes
    localparam logic [1:0] WAIT_NONE  = 2'h0;
    localparam logic [1:0] WAIT_ONE   = 2'h1;
    localparam logic [1:0] WAIT_TWO   = 2'h2;
    localparam logic [1:0] WAIT_TWO_P = 2'h3;
    localparam logic [1:0] ONE_2      = 2'h1;
    localparam logic [1:0] ZERO_2     = 2'h0;
    // bus cycle phases
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_STROBE  = 3'b010,
        ST_WAIT    = 3'b011,
        ST_HOLD    = 3'b100,
        ST_RECOVER = 3'b101
    } phase_t;
endpackage

// file: src/external_memory_interface.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - muxed low bus, high bus, latch, strobes
// - enabled interface overrides port directions
// - each access decoded internal or external
// - address valid at latch fall, low after
// - internal accesses show bus, no strobes
// - control bit 7 enables interface pins
// - disabled: no fold onto internal SRAM
// - pull-ups follow port output bits
// - keeper holds last value when released
// - four selectable wait settings
// - two sectors, independent wait settings
// - trailing latch pulse only before RAM access
// - control bit 6 is upper wait bit0
// - wait code meaning, extra recover cycle
// - sector limit field, 0x2000 multiples
// - keeper independent of interface enable
// - high mask releases top high pins
module external_memory_interface (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // control register ports
    input  wire logic        mcu_control_we,
    input  wire logic [7:0]  mcu_control_wdata,
    output logic      [7:0]  mcu_control_rdata,
    input  wire logic        ext_mcu_control_we,
    input  wire logic [7:0]  ext_mcu_control_wdata,
    output logic      [7:0]  ext_mcu_control_rdata,
    input  wire logic        special_function_io_we,
    input  wire logic [7:0]  special_function_io_wdata,
    output logic      [7:0]  special_function_io_rdata,
    // cpu data memory side
    input  wire logic        cpu_req,
    input  wire logic        cpu_write,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_next_ram,
    input  wire logic [15:0] internal_top,
    output logic             cpu_busy,
    output logic             cpu_rvalid,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_external,
    output logic             cpu_unmapped,
    // normal port settings for the dedicated pins
    input  wire logic [7:0]  port_a_out,
    input  wire logic [7:0]  port_a_dir,
    input  wire logic [7:0]  port_c_out,
    input  wire logic [7:0]  port_c_dir,
    // pins
    input  wire logic [7:0]  muxed_addr_data_in,
    output logic      [7:0]  muxed_addr_data_out,
    output logic      [7:0]  muxed_addr_data_oe_n,
    output logic      [7:0]  muxed_pullup_en,
    output logic      [7:0]  high_address_bus_out,
    output logic      [7:0]  high_address_bus_oe_n,
    output logic             addr_latch,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    output logic             if_active
);

    logic [7:0]              mcu_ctrl_ff;
    logic [7:0]              emcu_ctrl_ff;
    logic [7:0]              sfio_ff;
    ext_mem_if_pkg::phase_t        phase_ff;
    logic [1:0]              wait_cnt_ff;
    logic [1:0]              wait_code_ff;
    logic                    ext_ff;
    logic                    write_ff;
    logic                    next_ram_ff;
    logic [15:0]             addr_ff;
    logic [7:0]              wdata_ff;
    logic [7:0]              keep_ff;
    logic                    rvalid_ff;
    logic [7:0]              rdata_ff;
    logic                    ale_ff;
    logic                    ext_en;
    logic                    keeper_en;
    logic                    req_ext;
    logic [1:0]              req_wait;
    logic [3:0]              released;
    logic [7:0]              hi_mask;
    logic                    drive_ad;

    // sector boundary from limit code
    function automatic logic [15:0] sector_limit(
        input logic [2:0] code
    );
        sector_limit = SECTOR_STEP_MUL(code);
    endfunction

    function automatic logic [15:0] SECTOR_STEP_MUL(input logic [2:0] c);
        SECTOR_STEP_MUL = ext_mem_if_pkg::SECTOR_STEP * {13'h0000, c};
    endfunction

    assign ext_en    = mcu_ctrl_ff[ext_mem_if_pkg::ENABLE_BIT];
    assign keeper_en = sfio_ff[ext_mem_if_pkg::SF_KEEPER_BIT];

    // register writes
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            mcu_ctrl_ff  <= ext_mem_if_pkg::CTRL_RESET;
            emcu_ctrl_ff <= ext_mem_if_pkg::CTRL_RESET;
            sfio_ff      <= ext_mem_if_pkg::CTRL_RESET;
        end
        else
        begin
            if (mcu_control_we)
                mcu_ctrl_ff <= mcu_control_wdata;
            if (ext_mcu_control_we)
                emcu_ctrl_ff <= ext_mcu_control_wdata;
            if (special_function_io_we)
                sfio_ff <= special_function_io_wdata;
        end
    end

    assign mcu_control_rdata         = mcu_ctrl_ff;
    assign ext_mcu_control_rdata     = emcu_ctrl_ff;
    assign special_function_io_rdata = sfio_ff;

    // access decode and sector wait selection
    always_comb
    begin
        logic [2:0] lim;
        lim = emcu_ctrl_ff[ext_mem_if_pkg::EXT_LIMIT_LSB +: ext_mem_if_pkg::LIMIT_W];
        req_ext = (cpu_addr > internal_top);
        if (lim != 3'h0 && cpu_addr < sector_limit(lim))
            req_wait = {emcu_ctrl_ff[ext_mem_if_pkg::EXT_LOWER_W1_BIT],
                        emcu_ctrl_ff[ext_mem_if_pkg::EXT_LOWER_W0_BIT]};
        else
            req_wait = {emcu_ctrl_ff[ext_mem_if_pkg::EXT_UPPER_W1_BIT],
                        mcu_ctrl_ff[ext_mem_if_pkg::UPPER_W0_BIT]};
    end

    // external access while disabled is unmapped, never folded
    assign cpu_external = req_ext;
    assign cpu_unmapped = cpu_req && req_ext && !ext_en;

    // cycle sequencer
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            phase_ff     <= ext_mem_if_pkg::ST_IDLE;
            wait_cnt_ff  <= ext_mem_if_pkg::ZERO_2;
            wait_code_ff <= ext_mem_if_pkg::WAIT_NONE;
            ext_ff       <= 1'b0;
            write_ff     <= 1'b0;
            next_ram_ff  <= 1'b0;
            addr_ff      <= 16'h0000;
            wdata_ff     <= 8'h00;
        end
        else
        begin
            case (phase_ff)
                ext_mem_if_pkg::ST_IDLE:
                begin
                    if (cpu_req && ext_en)
                    begin
                        phase_ff     <= ext_mem_if_pkg::ST_ADDR;
                        ext_ff       <= req_ext;
                        write_ff     <= cpu_write;
                        addr_ff      <= cpu_addr;
                        wdata_ff     <= cpu_wdata;
                        wait_code_ff <= req_ext ? req_wait
                                                : ext_mem_if_pkg::WAIT_NONE;
                        next_ram_ff  <= cpu_next_ram;
                    end
                end
                ext_mem_if_pkg::ST_ADDR:
                begin
                    phase_ff    <= ext_mem_if_pkg::ST_STROBE;
                    wait_cnt_ff <= (wait_code_ff == ext_mem_if_pkg::WAIT_TWO_P)
                                   ? ext_mem_if_pkg::WAIT_TWO : wait_code_ff;
                end
                ext_mem_if_pkg::ST_STROBE:
                begin
                    if (wait_cnt_ff != ext_mem_if_pkg::ZERO_2)
                        wait_cnt_ff <= wait_cnt_ff - ext_mem_if_pkg::ONE_2;
                    else
                        phase_ff <= ext_mem_if_pkg::ST_HOLD;
                end
                ext_mem_if_pkg::ST_HOLD:
                begin
                    if (wait_code_ff == ext_mem_if_pkg::WAIT_TWO_P)
                        phase_ff <= ext_mem_if_pkg::ST_RECOVER;
                    else
                        phase_ff <= ext_mem_if_pkg::ST_IDLE;
                end
                ext_mem_if_pkg::ST_RECOVER:
                    phase_ff <= ext_mem_if_pkg::ST_IDLE;
                default:
                    phase_ff <= ext_mem_if_pkg::ST_IDLE;
            endcase
        end
    end

    assign cpu_busy = (phase_ff != ext_mem_if_pkg::ST_IDLE);

    // latch strobe: high only in the address phase, and trailing pulse
    always_ff @(posedge clock)
    begin
        if (!resetn)
            ale_ff <= 1'b0;
        else
            ale_ff <= ((phase_ff == ext_mem_if_pkg::ST_IDLE) && cpu_req && ext_en)
                      || ((phase_ff == ext_mem_if_pkg::ST_HOLD)
                          && (wait_code_ff != ext_mem_if_pkg::WAIT_TWO_P)
                          && next_ram_ff)
                      || ((phase_ff == ext_mem_if_pkg::ST_RECOVER)
                          && next_ram_ff);
    end
    assign addr_latch = ale_ff & ext_en;

    // strobes only for external accesses
    assign read_strobe_n  = !(ext_en && ext_ff && !write_ff
                              && phase_ff == ext_mem_if_pkg::ST_STROBE);
    assign write_strobe_n = !(ext_en && ext_ff && write_ff
                              && phase_ff == ext_mem_if_pkg::ST_STROBE);

    // read data capture at end of strobe
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 8'h00;
        end
        else
        begin
            rvalid_ff <= 1'b0;
            if (phase_ff == ext_mem_if_pkg::ST_STROBE
                && wait_cnt_ff == ext_mem_if_pkg::ZERO_2
                && ext_ff && !write_ff)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= muxed_addr_data_in;
            end
        end
    end
    assign cpu_rvalid = rvalid_ff;
    assign cpu_rdata  = rdata_ff;

    // bus keeper remembers last driven value
    always_ff @(posedge clock)
    begin
        if (!resetn)
            keep_ff <= 8'h00;
        else if (!(&muxed_addr_data_oe_n))
            keep_ff <= muxed_addr_data_out;
    end

    // low bus drive: address in addr phase, write data during strobe
    assign drive_ad = ext_en && (phase_ff == ext_mem_if_pkg::ST_ADDR
                      || (write_ff && phase_ff == ext_mem_if_pkg::ST_STROBE)
                      || (write_ff && phase_ff == ext_mem_if_pkg::ST_HOLD));
    always_comb
    begin
        if (drive_ad)
        begin
            muxed_addr_data_out  = (phase_ff == ext_mem_if_pkg::ST_ADDR)
                                   ? addr_ff[7:0] : wdata_ff;
            muxed_addr_data_oe_n = 8'h00;
        end
        else if (ext_en)
        begin
            muxed_addr_data_out  = keep_ff;
            muxed_addr_data_oe_n = 8'hFF;
        end
        else
        begin
            muxed_addr_data_out  = port_a_out;
            muxed_addr_data_oe_n = ~port_a_dir;
        end
    end

    // pull-ups from port bits; keeper independent of enable
    assign muxed_pullup_en = port_a_out
                             | ({8{keeper_en}} & keep_ff);

    // high byte mask releases top pins to port use
    assign released = {1'b0, sfio_ff[ext_mem_if_pkg::SF_MASK_LSB +: 3]}
                      + {3'h0, &sfio_ff[ext_mem_if_pkg::SF_MASK_LSB +: 3]};
    assign hi_mask  = 8'hFF >> released;
    always_comb
    begin
        if (ext_en)
        begin
            high_address_bus_out  = (addr_ff[15:8] & hi_mask)
                                    | (port_c_out & ~hi_mask);
            high_address_bus_oe_n = ~(hi_mask | port_c_dir);
        end
        else
        begin
            high_address_bus_out  = port_c_out;
            high_address_bus_oe_n = ~port_c_dir;
        end
    end

    assign if_active = ext_en;

endmodule
`default_nettype wire

// file: verification/ext_mem_if_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_if_sram_model (
    // bus pins
    input  wire logic [7:0] ad,
    input  wire logic [7:0] hi,
    input  wire logic       latch,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    // value offered on the low bus
    output logic      [7:0] drive
);
    logic [7:0]  cells [65536];
    logic [7:0]  low_ff;
    wire  [15:0] addr = {hi, low_ff};
    // octal latch closes as the strobe falls, no clock needed
    always @(negedge latch)
        low_ff = ad;
    // cell follows the bus while the write strobe is low
    always @(wr_n or ad or addr)
        if (!wr_n)
            cells[addr] = ad;
    // offers the cell value only inside the read strobe, else its inverse
    assign drive = !rd_n ? cells[addr] : ~cells[addr];
endmodule
`default_nettype wire

// file: verification/external_memory_interface_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_if_checker (
    // clock and reset
    input wire logic        clock,
    input wire logic        resetn,
    // control register
    input wire logic        mcu_control_we,
    input wire logic [7:0]  mcu_control_wdata,
    input wire logic [7:0]  mcu_control_rdata,
    // cpu side
    input wire logic        cpu_req,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_busy,
    input wire logic        cpu_rvalid,
    input wire logic        cpu_external,
    input wire logic        cpu_unmapped,
    // pins
    input wire logic [7:0]  port_a_dir,
    input wire logic [7:0]  muxed_addr_data_out,
    input wire logic [7:0]  muxed_addr_data_oe_n,
    input wire logic        addr_latch,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        if_active
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // request accepted at this edge
    wire [7:0] addr_lo = cpu_addr[7:0];
    wire       taken = !cpu_busy && cpu_req && if_active;

    a_latch_addr_out: assert property (taken |=> addr_latch
        && muxed_addr_data_out == $past(addr_lo))
        else $error("address not shown with latch");
    a_internal_inert: assert property (taken && !cpu_external
        |=> (read_strobe_n && write_strobe_n) [*3])
        else $error("strobe on internal access");
    a_read_len: assert property ($fell(read_strobe_n)
        |-> ##[1:3] (read_strobe_n && cpu_rvalid))
        else $error("read strobe length wrong");
    a_write_len: assert property ($fell(write_strobe_n)
        |-> ##[1:3] write_strobe_n)
        else $error("write strobe too long");
    a_strobe_busy: assert property (!read_strobe_n || !write_strobe_n
        |-> !addr_latch && cpu_busy)
        else $error("latch or idle during strobe");
    a_off_quiet: assert property (!if_active && !cpu_busy
        |-> read_strobe_n && write_strobe_n && !addr_latch)
        else $error("activity while disabled");
    a_off_pins: assert property (!if_active
        |-> muxed_addr_data_oe_n == ~port_a_dir)
        else $error("port direction not followed");
    a_off_unmapped: assert property (!if_active && cpu_req
        && cpu_external |-> cpu_unmapped)
        else $error("external access not flagged");
    a_ctrl_readback: assert property (mcu_control_we
        |=> mcu_control_rdata == $past(mcu_control_wdata))
        else $error("control readback wrong");

    c_read: cover property ($fell(read_strobe_n));
    c_write: cover property ($fell(write_strobe_n));
    c_unmapped: cover property (cpu_unmapped);
endmodule
bind external_memory_interface ext_mem_if_checker chk (
    .clock                (clock),
    .resetn               (resetn),
    .mcu_control_we       (mcu_control_we),
    .mcu_control_wdata    (mcu_control_wdata),
    .mcu_control_rdata    (mcu_control_rdata),
    .cpu_req              (cpu_req),
    .cpu_addr             (cpu_addr),
    .cpu_busy             (cpu_busy),
    .cpu_rvalid           (cpu_rvalid),
    .cpu_external         (cpu_external),
    .cpu_unmapped         (cpu_unmapped),
    .port_a_dir           (port_a_dir),
    .muxed_addr_data_out  (muxed_addr_data_out),
    .muxed_addr_data_oe_n (muxed_addr_data_oe_n),
    .addr_latch           (addr_latch),
    .read_strobe_n        (read_strobe_n),
    .write_strobe_n       (write_strobe_n),
    .if_active            (if_active)
);
`default_nettype wire

// file: verification/external_memory_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module external_memory_interface_test;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        mcu_control_we = 1'b0, ext_mcu_control_we = 1'b0;
    logic        special_function_io_we = 1'b0;
    logic [7:0]  mcu_control_wdata = 8'h00, ext_mcu_control_wdata = 8'h00;
    logic [7:0]  special_function_io_wdata = 8'h00, cpu_wdata = 8'h00;
    logic [7:0]  mcu_control_rdata, ext_mcu_control_rdata, cpu_rdata, rd;
    logic [7:0]  special_function_io_rdata, muxed_pullup_en, mem_data;
    logic        cpu_req = 1'b0, cpu_write = 1'b0, cpu_next_ram = 1'b0;
    logic [15:0] cpu_addr = 16'h0000, internal_top = 16'h025F;
    logic        cpu_busy, cpu_rvalid, cpu_external, cpu_unmapped;
    logic [7:0]  port_a_out = 8'h00, port_a_dir = 8'h00;
    logic [7:0]  port_c_out = 8'h00, port_c_dir = 8'h00;
    logic [7:0]  muxed_addr_data_out, muxed_addr_data_oe_n;
    logic [7:0]  high_address_bus_out, high_address_bus_oe_n;
    logic        addr_latch, read_strobe_n, write_strobe_n, if_active;
    wire  [7:0]  muxed_addr_data_in;
    logic [15:0] sa [3] = '{16'h1FFF, 16'h2000, 16'h0260};
    int          sl [3] = '{5, 3, 5};
    int          mismatches = 0, n_compared = 0, lat = 0, lcnt = 0;

    external_memory_interface dut (
        .clock                     (clock),
        .resetn                    (resetn),
        .mcu_control_we            (mcu_control_we),
        .mcu_control_wdata         (mcu_control_wdata),
        .mcu_control_rdata         (mcu_control_rdata),
        .ext_mcu_control_we        (ext_mcu_control_we),
        .ext_mcu_control_wdata     (ext_mcu_control_wdata),
        .ext_mcu_control_rdata     (ext_mcu_control_rdata),
        .special_function_io_we    (special_function_io_we),
        .special_function_io_wdata (special_function_io_wdata),
        .special_function_io_rdata (special_function_io_rdata),
        .cpu_req                   (cpu_req),
        .cpu_write                 (cpu_write),
        .cpu_addr                  (cpu_addr),
        .cpu_wdata                 (cpu_wdata),
        .cpu_next_ram              (cpu_next_ram),
        .internal_top              (internal_top),
        .cpu_busy                  (cpu_busy),
        .cpu_rvalid                (cpu_rvalid),
        .cpu_rdata                 (cpu_rdata),
        .cpu_external              (cpu_external),
        .cpu_unmapped              (cpu_unmapped),
        .port_a_out                (port_a_out),
        .port_a_dir                (port_a_dir),
        .port_c_out                (port_c_out),
        .port_c_dir                (port_c_dir),
        .muxed_addr_data_in        (muxed_addr_data_in),
        .muxed_addr_data_out       (muxed_addr_data_out),
        .muxed_addr_data_oe_n      (muxed_addr_data_oe_n),
        .muxed_pullup_en           (muxed_pullup_en),
        .high_address_bus_out      (high_address_bus_out),
        .high_address_bus_oe_n     (high_address_bus_oe_n),
        .addr_latch                (addr_latch),
        .read_strobe_n             (read_strobe_n),
        .write_strobe_n            (write_strobe_n),
        .if_active                 (if_active)
    );
    ext_mem_if_sram_model mem (.ad(muxed_addr_data_in), .hi(high_address_bus_out),
        .latch(addr_latch), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
        .drive(mem_data));
    // wire level from both parties; board delay gives latch hold time
    assign #1 muxed_addr_data_in = (~muxed_addr_data_oe_n
        & muxed_addr_data_out) | (muxed_addr_data_oe_n & mem_data);
    always #5 clock = ~clock;
    always @(posedge addr_latch) lcnt++;

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one-cycle write pulse to register sel
    task automatic set_reg(input int sel, input logic [7:0] v);
        @(posedge clock) #1;
        mcu_control_we = (sel == 0);
        ext_mcu_control_we = (sel == 1);
        special_function_io_we = (sel == 2);
        mcu_control_wdata = v;
        ext_mcu_control_wdata = v;
        special_function_io_wdata = v;
        @(posedge clock) #1;
        mcu_control_we = 1'b0;
        ext_mcu_control_we = 1'b0;
        special_function_io_we = 1'b0;
    endtask

    // one access; lat counts edges from request to read data
    task automatic access(input logic w, input logic [15:0] a,
                          input logic [7:0] d, input logic nr);
        int n;
        @(posedge clock) #1;
        cpu_req = 1'b1;
        cpu_write = w;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_next_ram = nr;
        @(posedge clock) #1;
        cpu_req = 1'b0;
        for (n = 0; n < 20 && cpu_busy === 1'b1; n++)
        begin
            @(posedge clock) #1;
            if (cpu_rvalid === 1'b1)
            begin
                rd = cpu_rdata;
                lat = n + 2;
            end
        end
        if (cpu_busy !== 1'b0)
        begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        #1 resetn = 1'b1;
        chk("mcu_control", 8'h00, mcu_control_rdata);
        chk("ext_mcu_control", 8'h00, ext_mcu_control_rdata);
        chk("special_io", 8'h00, special_function_io_rdata);
        $display("test reset done");
        for (int c = 0; c < 4; c++)
        begin
            set_reg(0, {1'b1, c[0], 6'h00});
            set_reg(1, {6'h00, c[1], 1'b0});
            chk("mcu_control", {1'b1, c[0], 6'h00}, mcu_control_rdata);
            access(1'b1, 16'(16'h1230 + c), 8'(8'hA5 ^ c), 1'b0);
            access(1'b0, 16'(16'h1230 + c), 8'h00, 1'b0);
            chk("read data", 8'(8'hA5 ^ c), rd);
            chk("wait latency", (c == 0) ? 3 : (c == 1) ? 4 : 5, 16'(lat));
        end
        $display("test waits done");
        set_reg(0, 8'h80);
        set_reg(1, 8'h18);
        foreach (sa[i])
        begin
            access(1'b0, sa[i], 8'h00, 1'b0);
            chk("sector latency", 16'(sl[i]), 16'(lat));
        end
        chk("keeper value", 8'h60, muxed_addr_data_out);
        chk("bus released", 8'hFF, muxed_addr_data_oe_n);
        $display("test sectors done");
        lcnt = 0;
        access(1'b0, 16'h3000, 8'h00, 1'b1);
        chk("latch pulses", 16'h0002, 16'(lcnt));
        lcnt = 0;
        access(1'b0, 16'h0100, 8'h00, 1'b0);
        chk("internal decode", 1'b0, cpu_external);
        chk("internal latch", 16'h0001, 16'(lcnt));
        $display("test latch done");
        port_c_out = 8'hA0;
        set_reg(2, 8'h18);
        chk("high pins", 8'hA1, high_address_bus_out);
        chk("high dirs", 8'hE0, high_address_bus_oe_n);
        $display("test mask done");
        set_reg(0, 8'h00);
        port_a_out = 8'h3C;
        port_a_dir = 8'h0F;
        cpu_addr = 16'h4000;
        cpu_req = 1'b1;
        #1 chk("unmapped", 1'b1, cpu_unmapped);
        chk("pin dirs", 8'hF0, muxed_addr_data_oe_n);
        chk("pull-ups", 8'h3C, muxed_pullup_en);
        chk("high port", 8'hA0, high_address_bus_out);
        @(posedge clock) #1;
        cpu_req = 1'b0;
        chk("busy off", 1'b0, cpu_busy);
        $display("test disabled done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
